//--- rtl/smcg_top.sv
// sleep mode controller with clock gating and ahb-lite registers
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module smcg_top
   import smcg_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // core side
   input wire logic sleep_exec,
   input wire logic [SMCG_NWAKE-1:0] wake_req,
   // clock enables out
   output smcg_clk_t clk_en,
   output smcg_pclk_t pclk_en,
   output logic sleeping,
   output logic core_run,
   // analog control
   output logic conv_start,
   output logic conv_extended,
   output logic comparator_off,
   output logic vref_en,
   output logic inbuf_en,
   output logic mux_to_comp,
   output logic wdt_run
);
   typedef enum logic [1:0] {SMCG_RUN, SMCG_SLEEP, SMCG_HALT} smcg_st_t;

   smcg_st_t state; // sleep sequencer
   logic [8:0] ctrl; // control bits
   logic [7:0] peripheral_clock_gate; // gate register
   smcg_sm_t mode; // latched mode
   logic [2:0] halt_cnt; // wake halt counter
   logic wake; // qualified wake
   logic conv_was_on; // converter powered last cycle
   logic ap_valid; // address phase captured
   logic ap_write;
   logic [7:0] ap_addr;
   smcg_sm_t sleep_mode_select;
   logic sleep_enable_bit;
   logic next_conv_on;
   logic sleep_go;

   assign sleep_mode_select = smcg_sm_t'(ctrl[SMCG_CTRL_SM_LO +: 2]);
   assign sleep_enable_bit = ctrl[SMCG_CTRL_SLEEP_EN];
   // converter is live only when enabled and not gated
   assign next_conv_on = ctrl[SMCG_CTRL_ADEN] & ~peripheral_clock_gate[SMCG_GATE_ADC];
   assign sleep_go = sleep_exec & sleep_enable_bit & (state == SMCG_RUN);

   // wake qualifier
   smcg_wake_qual u_wake (
      .clk(hclk),
      .rst_n(hresetn),
      .mode(mode),
      .ext_level(ctrl[SMCG_CTRL_LEVEL]),
      .req(wake_req),
      .wake(wake)
   );

   // address phase capture, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
      end else if (hready) begin
         ap_valid <= hsel & htrans[1];
         ap_write <= hwrite;
         ap_addr <= haddr;
      end
   end

   // control register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= SMCG_CTRL_RST;
      end else if (ap_valid && ap_write && ap_addr == SMCG_OFS_CTRL) begin
         ctrl <= hwdata[8:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         peripheral_clock_gate <= SMCG_GATE_RST;
      end else if (ap_valid && ap_write && ap_addr == SMCG_OFS_GATE) begin
         peripheral_clock_gate <= hwdata[7:0] & SMCG_GATE_MASK;
      end
   end

   // read data, registered one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr)
            SMCG_OFS_CTRL: hrdata <= {23'h00_0000, ctrl};
            SMCG_OFS_GATE: hrdata <= {24'h00_0000, peripheral_clock_gate};
            SMCG_OFS_STAT: hrdata <= {27'h000_0000, conv_extended, halt_cnt, sleeping};
            SMCG_OFS_WAKE: hrdata <= {25'h000_0000, wake_req};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // bus answer always ready and okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // sleep sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= SMCG_RUN;
         mode <= SMCG_SM_IDLE;
         halt_cnt <= 3'h0;
      end else begin
         unique case (state)
            SMCG_RUN: begin
               if (sleep_go) begin
                  mode <= sleep_mode_select;
                  state <= SMCG_SLEEP;
               end
            end
            SMCG_SLEEP: begin
               if (wake) begin
                  state <= SMCG_HALT;
                  halt_cnt <= 3'h0;
               end
            end
            SMCG_HALT: begin
               if (halt_cnt == SMCG_HALT_LAST) begin
                  state <= SMCG_RUN;
               end else begin
                  halt_cnt <= halt_cnt + 3'h1;
               end
            end
            default: state <= SMCG_RUN;
         endcase
      end
   end

   // domain clock enables, registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_en <= '1;
         sleeping <= 1'b0;
         core_run <= 1'b1;
      end else begin
         sleeping <= (state == SMCG_SLEEP);
         core_run <= (state == SMCG_RUN);
         clk_en <= '1;
         if (state == SMCG_SLEEP) begin
            clk_en.cpu <= 1'b0;
            clk_en.flash <= 1'b0;
            unique case (mode)
               SMCG_SM_IDLE: ;
               SMCG_SM_NRED: begin
                  clk_en.io <= 1'b0;
                  clk_en.pck <= 1'b0;
               end
               SMCG_SM_PDOWN, SMCG_SM_STBY: begin
                  clk_en.io <= 1'b0;
                  clk_en.adc <= 1'b0;
                  clk_en.pck <= 1'b0;
                  clk_en.osc <= (mode == SMCG_SM_STBY);
               end
            endcase
         end else if (state == SMCG_HALT) begin
            clk_en.cpu <= 1'b0;
            clk_en.flash <= 1'b0;
         end
      end
   end

   // peripheral clocks; gating only stops the clock so state is held
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pclk_en <= '1;
      end else begin
         pclk_en.timer1 <= ~peripheral_clock_gate[SMCG_GATE_T1];
         pclk_en.timer0 <= ~peripheral_clock_gate[SMCG_GATE_T0];
         pclk_en.serial <= ~peripheral_clock_gate[SMCG_GATE_SER];
         pclk_en.conv <= ~peripheral_clock_gate[SMCG_GATE_ADC];
      end
   end

   // converter start and extended-conversion flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_start <= 1'b0;
         conv_extended <= 1'b1;
         conv_was_on <= 1'b0;
         mux_to_comp <= 1'b1;
      end else begin
         conv_was_on <= next_conv_on;
         mux_to_comp <= ~peripheral_clock_gate[SMCG_GATE_ADC];
         conv_start <= sleep_go & next_conv_on &
                       (sleep_mode_select == SMCG_SM_IDLE || sleep_mode_select == SMCG_SM_NRED);
         if (!next_conv_on) begin
            conv_extended <= 1'b1;
         end else if (conv_start) begin
            conv_extended <= 1'b0;
         end
      end
   end

   // analog enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comparator_off <= 1'b0;
         vref_en <= 1'b0;
         inbuf_en <= 1'b1;
         wdt_run <= 1'b0;
      end else begin
         comparator_off <= ctrl[SMCG_CTRL_CMP_OFF] |
                           ((state == SMCG_SLEEP) && mode[1] && !ctrl[SMCG_CTRL_ACBG]);
         vref_en <= ctrl[SMCG_CTRL_BOD] |
                    (~ctrl[SMCG_CTRL_CMP_OFF] & ctrl[SMCG_CTRL_ACBG]) | next_conv_on;
         // buffers off when io and adc stop
         inbuf_en <= !((state == SMCG_SLEEP) && mode[1]);
         wdt_run <= ctrl[SMCG_CTRL_WDE];
      end
   end

   // a_ sleep checks
   sequence s_enter;
      sleep_go ##1 (state == SMCG_SLEEP);
   endsequence

   a_halt_four_cycles: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && wake) |=> (state == SMCG_HALT) [*4] ##1 (state == SMCG_RUN))
      else $error("wake halt not four cycles");
   a_sleep_needs_se: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_RUN && sleep_exec && !sleep_enable_bit) |=> state == SMCG_RUN)
      else $error("slept without sleep enable");
   a_idle_clocks: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && mode == SMCG_SM_IDLE) |=> !clk_en.cpu && clk_en.io)
      else $error("idle clocks wrong");
   a_nred_clocks: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && mode == SMCG_SM_NRED) |=> !clk_en.io && clk_en.adc && clk_en.osc)
      else $error("noise reduction clocks wrong");
   a_pdown_clocks: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && mode == SMCG_SM_PDOWN) |=> !clk_en.osc && !clk_en.adc)
      else $error("power-down clocks wrong");
   a_conv_start: assert property (@(posedge hclk) disable iff (!hresetn)
      s_enter |-> $past(next_conv_on) == conv_start || $past(sleep_mode_select) > SMCG_SM_NRED)
      else $error("conversion start wrong");
   a_gate_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate[7:4] == 4'h0)
      else $error("reserved gate bits set");
   a_timer1_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate[SMCG_GATE_T1] |=> !pclk_en.timer1)
      else $error("second timer not gated");
   a_inbuf_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && mode == SMCG_SM_PDOWN) |=> !inbuf_en)
      else $error("input buffers left on");
   a_wdt_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl[SMCG_CTRL_WDE] && state == SMCG_SLEEP) |=> wdt_run)
      else $error("watchdog stopped in sleep");
   // peripheral gate checks; a gated clock must drop on the very next cycle
   a_timer0_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate[SMCG_GATE_T0] |=> !pclk_en.timer0)
      else $error("first timer not gated");
   a_serial_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate[SMCG_GATE_SER] |=> !pclk_en.serial)
      else $error("serial clock not gated");
   a_conv_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate[SMCG_GATE_ADC] |=> !pclk_en.conv && !mux_to_comp)
      else $error("converter not gated");
   // clearing every gate bit must bring every peripheral clock back
   a_gate_resume: assert property (@(posedge hclk) disable iff (!hresetn)
      ((peripheral_clock_gate & SMCG_GATE_MASK) == SMCG_GATE_RST) |=> (&pclk_en))
      else $error("peripheral clock not resumed");
   // analog checks; in power-down and standby sleep the comparator may stay on only when it feeds from the reference
   a_comparator_deep: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == SMCG_SLEEP && mode[1] && !ctrl[SMCG_CTRL_ACBG]) |=> comparator_off)
      else $error("comparator left on in deep sleep");
   a_vref_demand: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl[SMCG_CTRL_BOD] || next_conv_on) |=> vref_en)
      else $error("reference off while needed");
   // a converter that was just switched off must flag its next conversion
   a_conv_extended: assert property (@(posedge hclk) disable iff (!hresetn)
      (conv_was_on && !next_conv_on) |=> conv_extended)
      else $error("extended conversion not flagged");
endmodule // smcg_top

//--- rtl/smcg_pkg.sv
// package: register map, fields and mode codes of the sleep and clock-gate block
package smcg_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] SMCG_OFS_CTRL = 8'h00;
   localparam logic [7:0] SMCG_OFS_GATE = 8'h04;
   localparam logic [7:0] SMCG_OFS_STAT = 8'h08;
   localparam logic [7:0] SMCG_OFS_WAKE = 8'h0c;
   // control register fields
   localparam int SMCG_CTRL_SLEEP_EN = 0;
   localparam int SMCG_CTRL_SM_LO = 1;
   localparam int SMCG_CTRL_CMP_OFF = 3;
   localparam int SMCG_CTRL_ACBG = 4;
   localparam int SMCG_CTRL_ADEN = 5;
   localparam int SMCG_CTRL_LEVEL = 6;
   localparam int SMCG_CTRL_BOD = 7;
   localparam int SMCG_CTRL_WDE = 8;
   // gate register fields
   localparam int SMCG_GATE_ADC = 0;
   localparam int SMCG_GATE_SER = 1;
   localparam int SMCG_GATE_T0 = 2;
   localparam int SMCG_GATE_T1 = 3;
   localparam logic [7:0] SMCG_GATE_MASK = 8'h0f;
   localparam logic [7:0] SMCG_GATE_RST = 8'h00;
   localparam logic [8:0] SMCG_CTRL_RST = 9'h000;
   // wake source bit positions
   localparam int SMCG_WK_ADC = 0;
   localparam int SMCG_WK_PROG = 1;
   localparam int SMCG_WK_EXT = 2;
   localparam int SMCG_WK_PCI = 3;
   localparam int SMCG_WK_SER = 4;
   localparam int SMCG_WK_WDT = 5;
   localparam int SMCG_WK_IO = 6;
   localparam int SMCG_NWAKE = 7;
   // wake halt beyond start-up
   localparam int SMCG_WAKE_HALT = 4;
   localparam logic [2:0] SMCG_HALT_LAST = 3'(SMCG_WAKE_HALT - 1);
   // sleep mode select codes
   typedef enum logic [1:0] {
      SMCG_SM_IDLE = 2'b00,
      SMCG_SM_NRED = 2'b01,
      SMCG_SM_PDOWN = 2'b10,
      SMCG_SM_STBY = 2'b11
   } smcg_sm_t;
   // clock domain enables
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic pck;
      logic osc;
   } smcg_clk_t;
   // peripheral clock enables
   typedef struct packed {
      logic timer1;
      logic timer0;
      logic serial;
      logic conv;
   } smcg_pclk_t;
endpackage

//--- rtl/smcg_wake_qual.sv
// wake-source qualifier: which enabled requests may wake the core in each mode
`timescale 1ns/100ps
module smcg_wake_qual
   import smcg_pkg::*;
(
   // mode and requests
   input wire logic clk,
   input wire logic rst_n,
   input wire smcg_sm_t mode,
   input wire logic ext_level,
   input wire logic [SMCG_NWAKE-1:0] req,
   // qualified wake
   output logic wake
);
   logic [SMCG_NWAKE-1:0] allow;

   // allowed source set per mode
   always_comb begin
      allow = '1;
      unique case (mode)
         SMCG_SM_IDLE: allow = '1;
         SMCG_SM_NRED: begin
            allow = '1;
            allow[SMCG_WK_IO] = 1'b0;
            allow[SMCG_WK_EXT] = ext_level;
         end
         SMCG_SM_PDOWN, SMCG_SM_STBY: begin
            allow = '0;
            allow[SMCG_WK_PCI] = 1'b1;
            allow[SMCG_WK_SER] = 1'b1;
            allow[SMCG_WK_WDT] = 1'b1;
            allow[SMCG_WK_EXT] = ext_level;
         end
      endcase
   end

   // registered so the wake pulse is glitch free
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake <= 1'b0;
      end else begin
         wake <= |(req & allow);
      end
   end
endmodule // smcg_wake_qual

//--- dv/smcg_core_model.sv
// core and peripheral stand-in that issues sleep and holds wake requests
`timescale 1ns/100ps
module smcg_core_model
   import smcg_pkg::*;
(
   // clock
   input wire logic hclk,
   // bench commands
   input wire logic do_sleep,
   input wire logic [SMCG_NWAKE-1:0] want,
   // block status
   input wire logic core_run,
   // toward the block
   output logic sleep_exec = 1'b0,
   output logic [SMCG_NWAKE-1:0] wake_req = 7'h00
);
   // sleep instruction one cycle after the command
   always_ff @(posedge hclk) begin
      sleep_exec <= do_sleep;
   end
   // hold wake level
   // a source drops its line only once the core runs, so a slow wake still sees it
   always_ff @(posedge hclk) begin
      if (want != 7'h00) begin
         wake_req <= want;
      end else if (core_run) begin
         wake_req <= 7'h00;
      end
   end
endmodule // smcg_core_model

//--- dv/test_sleep_mode_clock_gating.sv
// self-checking bench of the sleep and clock-gate block
`timescale 1ns/100ps
module test_sleep_mode_clock_gating;
   import smcg_pkg::*;
   // clock, reset and bus drive
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp;
   // core side
   logic do_sleep = 1'b0;
   logic [SMCG_NWAKE-1:0] want = 7'h00;
   logic sleep_exec;
   logic [SMCG_NWAKE-1:0] wake_req;
   // block outputs
   smcg_clk_t clk_en;
   smcg_pclk_t pclk_en;
   logic sleeping, core_run, conv_start, conv_extended, comparator_off;
   logic vref_en, inbuf_en, mux_to_comp, wdt_run;
   // verdict counters
   int bad_count = 0;
   int checked = 0;

   smcg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sleep_exec(sleep_exec), .wake_req(wake_req), .clk_en(clk_en),
      .pclk_en(pclk_en), .sleeping(sleeping), .core_run(core_run),
      .conv_start(conv_start), .conv_extended(conv_extended),
      .comparator_off(comparator_off), .vref_en(vref_en), .inbuf_en(inbuf_en),
      .mux_to_comp(mux_to_comp), .wdt_run(wdt_run));

   smcg_core_model core (.hclk(hclk), .do_sleep(do_sleep), .want(want),
      .core_run(core_run), .sleep_exec(sleep_exec), .wake_req(wake_req));

   // 250 MHz clock
   initial begin
      forever #2 hclk = ~hclk;
   end

   // verdict and end of run
   task automatic test_done;
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   // edges until hready sampled high, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         if (n > 50) begin
            bad_count++;
            test_done();
         end
      end while (hreadyout !== 1'b1);
   endtask

   // single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      chk("hresp", 32'h0000_0000, 32'(hresp));
   endtask

   // one sleep instruction
   task automatic pulse_sleep;
      @(posedge hclk);
      do_sleep <= 1'b1;
      @(posedge hclk);
      do_sleep <= 1'b0;
   endtask

   // values straight after reset
   task automatic t_reset;
      chk("pclk_en", 32'h0000_000f, 32'(pclk_en));
      bus(1'h0, SMCG_OFS_GATE, 32'h0000_0000, rd);
      chk("gate reset", 32'h0000_0000, rd);
   endtask

   // sleep entry, wake filtering and halt for one mode
   task automatic run_sleep(input logic [1:0] m, input logic lvl, input logic [5:0] exp_clk,
                            input logic [6:0] bad, input logic [6:0] good);
      logic conv_seen;
      int n;
      conv_seen = 1'b0;
      n = 0;
      // watchdog and converter on, sleep enabled
      bus(1'h1, SMCG_OFS_CTRL, {23'h0, 1'h1, 1'h0, lvl, 1'h1, 2'h0, m, 1'h1}, rd);
      pulse_sleep();
      while (sleeping !== 1'b1) begin
         @(posedge hclk);
         if (conv_start === 1'b1) begin
            conv_seen = 1'b1;
         end
         n++;
         if (n > 20) begin
            bad_count++;
            test_done();
         end
      end
      chk("conv_start", 32'(m < 2'h2), 32'(conv_seen));
      chk("clk_en", 32'(exp_clk), 32'(clk_en));
      chk("wdt_run", 32'h0000_0001, 32'(wdt_run));
      chk("inbuf_en", 32'(exp_clk[3:2] != 2'h0), 32'(inbuf_en));
      chk("comparator_off", 32'(m[1]), 32'(comparator_off));
      // sources outside the mode's wake set must not wake it
      want <= bad;
      repeat (8) @(posedge hclk);
      chk("sleeping held", 32'h0000_0001, 32'(sleeping));
      bus(1'h0, SMCG_OFS_WAKE, 32'h0000_0000, rd);
      chk("wake read", 32'(bad), rd);
      want <= good;
      n = 0;
      while (core_run !== 1'b1) begin
         @(posedge hclk);
         n++;
         if (n > 40) begin
            bad_count++;
            test_done();
         end
      end
      chk("wake halt", 32'h0000_0001, 32'(n > SMCG_WAKE_HALT));
      want <= 7'h00;
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0000, rd);
   endtask

   // sleep with enable clear must do nothing
   task automatic t_refuse;
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0004, rd);
      pulse_sleep();
      repeat (6) @(posedge hclk);
      chk("sleeping refused", 32'h0000_0000, 32'(sleeping));
      chk("clk_en running", 32'h0000_003f, 32'(clk_en));
   endtask

   // clock-gate register bits
   task automatic t_gate;
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0000, rd);
      bus(1'h1, SMCG_OFS_GATE, 32'hffff_ffff, rd);
      bus(1'h0, SMCG_OFS_GATE, 32'h0000_0000, rd);
      chk("gate read", 32'h0000_000f, rd);
      chk("pclk_en gated", 32'h0000_0000, 32'(pclk_en));
      chk("mux_to_comp", 32'h0000_0000, 32'(mux_to_comp));
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, SMCG_OFS_GATE, 32'(1 << i), rd);
         bus(1'h0, SMCG_OFS_GATE, 32'h0000_0000, rd);
         chk("pclk_en single", 32'(4'hf ^ (4'h1 << i)), 32'(pclk_en));
      end
      bus(1'h1, SMCG_OFS_GATE, 32'h0000_0000, rd);
      bus(1'h0, 8'h20, 32'h0000_0000, rd);
      chk("unmapped read", 32'h0000_0000, rd);
      chk("pclk_en ungated", 32'h0000_000f, 32'(pclk_en));
   endtask

   // reference users and converter restart
   task automatic t_vref;
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0080, rd);
      bus(1'h0, SMCG_OFS_STAT, 32'h0000_0000, rd);
      chk("vref_en brownout", 32'h0000_0001, 32'(vref_en));
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0020, rd);
      bus(1'h0, SMCG_OFS_STAT, 32'h0000_0000, rd);
      chk("conv_extended", 32'h0000_0001, 32'(conv_extended));
      chk("stat word", 32'h0000_0010, rd & 32'h0000_0011);
      bus(1'h1, SMCG_OFS_CTRL, 32'h0000_0000, rd);
      bus(1'h0, SMCG_OFS_STAT, 32'h0000_0000, rd);
      chk("vref_en none", 32'h0000_0000, 32'(vref_en));
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      run_sleep(2'h0, 1'h0, 6'h0f, 7'h00, 7'h40);
      run_sleep(2'h1, 1'h0, 6'h05, 7'h44, 7'h01);
      run_sleep(2'h2, 1'h1, 6'h00, 7'h43, 7'h04);
      run_sleep(2'h3, 1'h0, 6'h01, 7'h47, 7'h20);
      t_refuse();
      t_gate();
      t_vref();
      test_done();
   end
endmodule // test_sleep_mode_clock_gating
